// [cdf_cfg.svh]
// Purpose: shared constants of the clock divider fanout control logic
// Assumes: included by bare name from the controller, device and bench files
// Notes:   definitions only
`ifndef CDF_CFG_SVH
`define CDF_CFG_SVH
`define CDF_ADDR_FIXED     5'h1A
`define CDF_MASK_RESET     8'h00
`define CDF_REG_CTRL       12'h000
`define CDF_REG_STAT       12'h004
`define CDF_CTRL_ADDR_LSB  0
`define CDF_CTRL_RW_BIT    8
`define CDF_CTRL_DATA_LSB  16
`define CDF_STAT_BUSY_BIT  0
`define CDF_STAT_NACK_BIT  1
`define CDF_STAT_DONE_BIT  2
`define CDF_STAT_RDATA_LSB 8
`define CDF_CLK_PERIOD_NS  25
`define CDF_ENABLE_TIME_NS 1000
`define CDF_COMMIT_CYC     3
`define CDF_SCL_QUARTER    25
`endif

// [cdf_pkg.sv]
// Purpose: types shared by both ends of the link
// Assumes: nothing
// Notes:   one-hot state codes
package cdf_pkg;
  typedef enum logic [7:0] {
    SLV_IDLE  = 8'h01,
    SLV_ADDR  = 8'h02,
    SLV_ACK_A = 8'h04,
    SLV_WRITE = 8'h08,
    SLV_ACK_W = 8'h10,
    SLV_READ  = 8'h20,
    SLV_ACK_R = 8'h40,
    SLV_WAIT  = 8'h80
  } cdf_slv_st_t;
  typedef enum logic [3:0] {
    CTL_IDLE  = 4'h1,
    CTL_START = 4'h2,
    CTL_SHIFT = 4'h4,
    CTL_STOP  = 4'h8
  } cdf_ctl_st_t;
endpackage

// [cdf_i2c_if.sv]
// Purpose: two-wire link between controller and divider device
// Assumes: both lines are open drain with pull-ups
// Notes:   a line is low while any party enables its driver
`timescale 1ns/1ps
`default_nettype none
interface cdf_i2c_if;
  logic scl_line;
  logic sda_line;
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  assign scl_line = ~ctl_scl_oe;
  assign sda_line = ~(ctl_sda_oe | dev_sda_oe);
  modport ctl (output ctl_scl_o, ctl_scl_oe, ctl_sda_o, ctl_sda_oe, input scl_line, sda_line);
  modport dev (output dev_sda_o, dev_sda_oe, input scl_line, sda_line);
endinterface
`default_nettype wire

// [cdf_ctrl.sv]
// Purpose: bus controller end; software orders one transfer over APB
// Assumes: device never stretches the clock
// Notes:   CTRL write starts a transfer, STAT shows progress and read data
`timescale 1ns/1ps
`default_nettype none
`include "cdf_cfg.svh"
module cdf_ctrl
  import cdf_pkg::*;
#(
  parameter int QUARTER = `CDF_SCL_QUARTER
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        clk_en_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  cdf_i2c_if.ctl           bus
);
  if (QUARTER < 2 || QUARTER > 65535) begin : g_chk
    $error("QUARTER out of range");
  end

  cdf_ctl_st_t st_reg, st_next;
  logic [15:0] q_reg, q_next;
  logic [1:0]  ph_reg, ph_next;
  logic [3:0]  bit_reg, bit_next;
  logic        byte1_reg, byte1_next;
  logic [7:0]  shift_reg, shift_next;
  logic [6:0]  addr_reg, addr_next;
  logic        rw_reg, rw_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        busy_reg, busy_next, nack_reg, nack_next, done_reg, done_next;
  logic        scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
  logic        pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        tick;
  logic        rd_byte;

  assign bus.ctl_scl_o  = 1'b0;
  assign bus.ctl_sda_o  = 1'b0;
  assign bus.ctl_scl_oe = scl_oe_reg;
  assign bus.ctl_sda_oe = sda_oe_reg;
  assign prdata_o       = prdata_reg;
  assign pready_o       = pready_reg;
  assign pslverr_o      = pslverr_reg;

  always_comb begin
    st_next = st_reg; q_next = q_reg; ph_next = ph_reg; bit_next = bit_reg;
    byte1_next = byte1_reg; shift_next = shift_reg; addr_next = addr_reg;
    rw_next = rw_reg; wdata_next = wdata_reg; rdata_next = rdata_reg;
    busy_next = busy_reg; nack_next = nack_reg; done_next = done_reg;
    scl_oe_next = scl_oe_reg; sda_oe_next = sda_oe_reg;
    pready_next = 1'b0; pslverr_next = 1'b0; prdata_next = prdata_reg;
    tick = (q_reg == 16'(QUARTER - 1));
    rd_byte = byte1_reg & rw_reg;
    // ----------------------------------------------------------------
    // apb slave: answer one cycle into the access phase
    // ----------------------------------------------------------------
    if (psel_i && penable_i && !pready_reg) begin
      pready_next = 1'b1;
      prdata_next = 32'h0000_0000;
      if (paddr_i == `CDF_REG_CTRL) begin
        prdata_next[`CDF_CTRL_ADDR_LSB +: 7] = addr_reg;
        prdata_next[`CDF_CTRL_RW_BIT]        = rw_reg;
        prdata_next[`CDF_CTRL_DATA_LSB +: 8] = wdata_reg;
      end else if (paddr_i == `CDF_REG_STAT) begin
        prdata_next[`CDF_STAT_BUSY_BIT]       = busy_reg;
        prdata_next[`CDF_STAT_NACK_BIT]       = nack_reg;
        prdata_next[`CDF_STAT_DONE_BIT]       = done_reg;
        prdata_next[`CDF_STAT_RDATA_LSB +: 8] = rdata_reg;
      end else begin
        pslverr_next = 1'b1;
      end
    end
    // write acts on the edge that completes the access; ignored while busy
    if (psel_i && penable_i && pready_reg && pwrite_i && !busy_reg
        && paddr_i == `CDF_REG_CTRL) begin
      addr_next  = pwdata_i[`CDF_CTRL_ADDR_LSB +: 7];
      rw_next    = pwdata_i[`CDF_CTRL_RW_BIT];
      wdata_next = pwdata_i[`CDF_CTRL_DATA_LSB +: 8];
      busy_next  = 1'b1;
      nack_next  = 1'b0;
      done_next  = 1'b0;
      st_next    = CTL_START;
      q_next     = 16'h0000;
      ph_next    = 2'd0;
    end
    // ----------------------------------------------------------------
    // bit engine: four quarter phases per scl period
    // ----------------------------------------------------------------
    if (busy_reg) begin
      q_next = tick ? 16'h0000 : q_reg + 16'h0001;
      if (tick) begin
        ph_next = ph_reg + 2'd1;
        case (st_reg)
          CTL_START: begin
            if (ph_reg == 2'd1) sda_oe_next = 1'b1;
            if (ph_reg == 2'd2) scl_oe_next = 1'b1;
            if (ph_reg == 2'd3) begin
              st_next    = CTL_SHIFT;
              bit_next   = 4'd0;
              byte1_next = 1'b0;
              shift_next = {addr_reg, rw_reg};
            end
          end
          CTL_SHIFT: begin
            case (ph_reg)
              2'd0: begin
                if (bit_reg != 4'd8) sda_oe_next = ~rd_byte & ~shift_reg[7];
                else sda_oe_next = rd_byte;
              end
              2'd1: scl_oe_next = 1'b0;
              2'd2: begin
                if (bit_reg != 4'd8) shift_next = {shift_reg[6:0], bus.sda_line};
                else if (!rd_byte && bus.sda_line) nack_next = 1'b1;
              end
              default: begin
                scl_oe_next = 1'b1;
                if (bit_reg != 4'd8) begin
                  bit_next = bit_reg + 4'd1;
                end else if (nack_reg || byte1_reg) begin
                  if (rd_byte) rdata_next = shift_reg;
                  st_next = CTL_STOP;
                end else begin
                  byte1_next = 1'b1;
                  bit_next   = 4'd0;
                  shift_next = rw_reg ? 8'hFF : wdata_reg;
                end
              end
            endcase
          end
          CTL_STOP: begin
            if (ph_reg == 2'd0) sda_oe_next = 1'b1;
            if (ph_reg == 2'd1) scl_oe_next = 1'b0;
            if (ph_reg == 2'd2) sda_oe_next = 1'b0;
            if (ph_reg == 2'd3) begin
              st_next   = CTL_IDLE;
              busy_next = 1'b0;
              done_next = 1'b1;
            end
          end
          default: st_next = CTL_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= CTL_IDLE; q_reg <= 16'h0000; ph_reg <= 2'd0; bit_reg <= 4'd0;
      byte1_reg <= 1'b0; shift_reg <= 8'h00; addr_reg <= 7'h00; rw_reg <= 1'b0;
      wdata_reg <= 8'h00; rdata_reg <= 8'h00; busy_reg <= 1'b0; nack_reg <= 1'b0;
      done_reg <= 1'b0; scl_oe_reg <= 1'b0; sda_oe_reg <= 1'b0;
      pready_reg <= 1'b0; pslverr_reg <= 1'b0; prdata_reg <= 32'h0000_0000;
    end else if (clk_en_i) begin
      st_reg <= st_next; q_reg <= q_next; ph_reg <= ph_next; bit_reg <= bit_next;
      byte1_reg <= byte1_next; shift_reg <= shift_next; addr_reg <= addr_next;
      rw_reg <= rw_next; wdata_reg <= wdata_next; rdata_reg <= rdata_next;
      busy_reg <= busy_next; nack_reg <= nack_next; done_reg <= done_next;
      scl_oe_reg <= scl_oe_next; sda_oe_reg <= sda_oe_next;
      pready_reg <= pready_next; pslverr_reg <= pslverr_next; prdata_reg <= prdata_next;
    end
  end
endmodule
`default_nettype wire

// [cdf_device.sv]
// Purpose: divider device end: clock divider, fanout enables, two-wire slave
// Assumes: scl, sda, straps and ref_clk_i are slow against clock_i
// Notes:   ref_clk_i is sampled, so it must stay below a quarter of clock_i
`timescale 1ns/1ps
`default_nettype none
`include "cdf_cfg.svh"
// Overview of operation
// - selects 00..11 divide by 1,2,4,8
// - both selects low passes reference undivided
// - selects are asynchronous, synchronised here
// - mask bit 0 drives pair, 1 floats
// - mask bit n controls pair n
// - reset clears mask, all pairs enabled
// - valid writes set pair enables from mask
// - enable update independent of reference clock
// - address 11010 plus two strap bits
// - address byte lsb selects read/write
// - write: start, address, data, stop, acks
// - read: device returns mask, master acks, stop
// - start is sda fall while scl high
// - stop is sda rise while scl high
// - transmitter changes sda only while scl low
// - acknowledge held low across the clock high
// - board straps distinct addresses per device
// - enable change done within 1 us of stop
module cdf_device
  import cdf_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       clk_en_i,
  input  wire logic       ref_clk_i,
  input  wire logic       divide_select_hi_i,
  input  wire logic       divide_select_lo_i,
  input  wire logic       addr_strap_hi_i,
  input  wire logic       addr_strap_lo_i,
  cdf_i2c_if.dev          bus,
  output logic      [7:0] clock_out_pair_o,
  output logic      [7:0] clock_out_pair_inverted_o,
  output logic      [7:0] clock_out_enable_o
);
  localparam int ENABLE_CYC = `CDF_ENABLE_TIME_NS / `CDF_CLK_PERIOD_NS;
  if (`CDF_COMMIT_CYC > ENABLE_CYC) begin : g_chk
    $error("enable update slower than allowed");
  end

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------
  function automatic logic div_tap(input logic [1:0] sel, input logic [2:0] cnt,
                                   input logic ref_lvl);
    logic t;
    t = ref_lvl;
    case (sel)
      2'b01:   t = cnt[0];
      2'b10:   t = cnt[1];
      2'b11:   t = cnt[2];
      default: t = ref_lvl;
    endcase
    return t;
  endfunction

  // ------------------------------------------------------------------
  // divider and fanout
  // ------------------------------------------------------------------
  logic [1:0] sel_meta_reg, sel_meta_next;
  logic [1:0] sel_reg, sel_next;
  logic       ref_q_reg, ref_q_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] pair_reg, pair_next;
  logic [7:0] pair_n_reg, pair_n_next;
  logic [7:0] oe_reg, oe_next;
  logic [7:0] mask_reg, mask_next;
  logic       div_bit;

  always_comb begin
    div_bit       = 1'b0;
    // second stage is the only reader of the first
    sel_meta_next = {divide_select_hi_i, divide_select_lo_i};
    sel_next      = sel_meta_reg;
    ref_q_next    = ref_clk_i;
    cnt_next      = cnt_reg;
    if (ref_clk_i && !ref_q_reg) cnt_next = cnt_reg + 3'd1;
    div_bit       = div_tap(sel_reg, cnt_next, ref_clk_i);
    pair_next     = {8{div_bit}};
    pair_n_next   = {8{~div_bit}};
    oe_next       = ~mask_reg;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sel_meta_reg <= 2'b00;
      sel_reg      <= 2'b00;
      ref_q_reg    <= 1'b0;
      cnt_reg      <= 3'd0;
      pair_reg     <= 8'h00;
      pair_n_reg   <= 8'hFF;
      oe_reg       <= ~`CDF_MASK_RESET;
    end else if (clk_en_i) begin
      sel_meta_reg <= sel_meta_next;
      sel_reg      <= sel_next;
      ref_q_reg    <= ref_q_next;
      cnt_reg      <= cnt_next;
      pair_reg     <= pair_next;
      pair_n_reg   <= pair_n_next;
      oe_reg       <= oe_next;
    end
  end

  assign clock_out_pair_o          = pair_reg;
  assign clock_out_pair_inverted_o = pair_n_reg;
  assign clock_out_enable_o        = oe_reg;

  // ------------------------------------------------------------------
  // two-wire slave
  // ------------------------------------------------------------------
  cdf_slv_st_t st_reg, st_next;
  logic       scl_q_reg, scl_q_next, sda_q_reg, sda_q_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic       rw_reg, rw_next;
  logic       sda_oe_reg, sda_oe_next;
  logic [7:0] pend_reg, pend_next;
  logic       pend_vld_reg, pend_vld_next;
  logic       start_ev, stop_ev, rise_ev, fall_ev;
  logic [6:0] own_addr;

  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = sda_oe_reg;

  always_comb begin
    st_next = st_reg; bit_next = bit_reg; shift_next = shift_reg;
    rw_next = rw_reg; sda_oe_next = sda_oe_reg; pend_next = pend_reg;
    pend_vld_next = pend_vld_reg; mask_next = mask_reg;
    scl_q_next = bus.scl_line;
    sda_q_next = bus.sda_line;
    own_addr = {`CDF_ADDR_FIXED, addr_strap_hi_i, addr_strap_lo_i};
    start_ev = bus.scl_line && scl_q_reg && sda_q_reg && !bus.sda_line;
    stop_ev  = bus.scl_line && scl_q_reg && !sda_q_reg && bus.sda_line;
    rise_ev  = bus.scl_line && !scl_q_reg;
    fall_ev  = !bus.scl_line && scl_q_reg;
    if (start_ev) begin
      // a repeated start drops any byte not yet closed by a stop
      st_next = SLV_ADDR; bit_next = 4'd0; sda_oe_next = 1'b0;
      pend_vld_next = 1'b0;
    end else if (stop_ev) begin
      st_next = SLV_IDLE; sda_oe_next = 1'b0;
      if (pend_vld_reg) mask_next = pend_reg;
      pend_vld_next = 1'b0;
    end else begin
      case (st_reg)
        SLV_ADDR, SLV_WRITE: begin
          if (rise_ev) begin
            shift_next = {shift_reg[6:0], bus.sda_line};
            bit_next   = bit_reg + 4'd1;
          end else if (fall_ev && bit_reg == 4'd8) begin
            bit_next = 4'd0;
            if (st_reg == SLV_WRITE) begin
              sda_oe_next = 1'b1;
              pend_next = shift_reg;
              pend_vld_next = 1'b1;
              st_next = SLV_ACK_W;
            end else if (shift_reg[7:1] == own_addr) begin
              sda_oe_next = 1'b1;
              rw_next = shift_reg[0];
              st_next = SLV_ACK_A;
            end else begin
              st_next = SLV_WAIT;
            end
          end
        end
        SLV_ACK_A: begin
          if (fall_ev) begin
            bit_next = 4'd0;
            if (rw_reg) begin
              sda_oe_next = ~mask_reg[7];
              shift_next = {mask_reg[6:0], 1'b0};
              st_next = SLV_READ;
            end else begin
              sda_oe_next = 1'b0;
              st_next = SLV_WRITE;
            end
          end
        end
        SLV_ACK_W: begin
          if (fall_ev) begin
            sda_oe_next = 1'b0;
            st_next = SLV_WAIT; // one data byte per write; more are not acked
          end
        end
        SLV_READ: begin
          if (rise_ev) begin
            bit_next = bit_reg + 4'd1;
          end else if (fall_ev) begin
            if (bit_reg == 4'd8) begin
              sda_oe_next = 1'b0;
              st_next = SLV_ACK_R;
            end else begin
              sda_oe_next = ~shift_reg[7];
              shift_next = {shift_reg[6:0], 1'b0};
            end
          end
        end
        SLV_ACK_R: begin
          if (fall_ev) st_next = SLV_WAIT;
        end
        default: st_next = st_reg;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= SLV_IDLE; scl_q_reg <= 1'b1; sda_q_reg <= 1'b1;
      bit_reg <= 4'd0; shift_reg <= 8'h00; rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0; pend_reg <= 8'h00; pend_vld_reg <= 1'b0;
      mask_reg <= `CDF_MASK_RESET;
    end else if (clk_en_i) begin
      st_reg <= st_next; scl_q_reg <= scl_q_next; sda_q_reg <= sda_q_next;
      bit_reg <= bit_next; shift_reg <= shift_next; rw_reg <= rw_next;
      sda_oe_reg <= sda_oe_next; pend_reg <= pend_next; pend_vld_reg <= pend_vld_next;
      mask_reg <= mask_next;
    end
  end
endmodule
`default_nettype wire

// [cdf_link_properties.sv]
// Purpose: protocol properties of the two-wire link between both ends
// Assumes: controller built with QUARTER of at least 8
// Notes:   sees only resolved lines and the device data driver enable
`timescale 1ns/1ps
`default_nettype none
module cdf_link_properties (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl_line,
  input wire logic sda_line,
  input wire logic dev_sda_oe
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  chk_start_scl_high: assert property ($fell(sda_line) && scl_line |-> scl_line [*4])
    else $error("start not followed by clock high");
  chk_stop_scl_high: assert property ($rose(sda_line) && scl_line |-> scl_line [*4])
    else $error("stop not followed by idle clock");
  chk_stop_dev_quiet: assert property ($rose(sda_line) && scl_line |-> !dev_sda_oe [*4])
    else $error("device drives data after stop");
  chk_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl_line)
    else $error("device moved data while clock high");
  chk_high_change_ctl: assert property (
    scl_line && $past(scl_line) && $changed(sda_line) |-> !dev_sda_oe && !$past(dev_sda_oe))
    else $error("data changed under clock high by device");
  chk_ack_through_high: assert property ($rose(scl_line) && dev_sda_oe |-> dev_sda_oe [*8])
    else $error("acknowledge released during clock high");
  chk_scl_high_len: assert property ($rose(scl_line) |-> scl_line [*8])
    else $error("clock high phase too short");
  chk_dev_answer_quick: assert property ($changed(dev_sda_oe) |->
    $past(scl_line, 2) || $past(scl_line, 3) || $past(scl_line, 4))
    else $error("device data change not right after clock fall");
endmodule
`default_nettype wire

// [tb.sv]
// Purpose: self-checking bench, controller and divider device joined by the link
// Assumes: QUARTER 8 keeps a transfer near 640 clock cycles
// Notes:   software reaches the device only through the APB registers
`timescale 1ns/1ps
`default_nettype none
`include "cdf_cfg.svh"
module tb;
  logic        clock_i, rst_i, ref_clk, fs_hi, fs_lo, ad_hi, ad_lo;
  logic        psel, penable, pwrite, pready, pslverr, slv, sda_prev, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, p;
  logic [7:0]  pair, pair_n, en_o, mask, old, en_prev;
  logic [1:0]  refcnt;
  int          errors, checks_done, seed, cyc, stop_cyc, chg_cyc;

  cdf_i2c_if bus_if();
  cdf_ctrl #(.QUARTER(8)) i_cdf_ctrl (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(clk_en),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .bus(bus_if));
  cdf_device i_cdf_device (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(clk_en),
    .ref_clk_i(ref_clk), .divide_select_hi_i(fs_hi), .divide_select_lo_i(fs_lo),
    .addr_strap_hi_i(ad_hi), .addr_strap_lo_i(ad_lo), .bus(bus_if), .clock_out_pair_o(pair),
    .clock_out_pair_inverted_o(pair_n), .clock_out_enable_o(en_o));
  cdf_link_properties i_cdf_link_properties (.clock_i(clock_i), .rst_i(rst_i),
    .scl_line(bus_if.scl_line), .sda_line(bus_if.sda_line), .dev_sda_oe(bus_if.dev_sda_oe));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  // reference at an eighth of clock_i; stop and enable-change stamps for the 1 us check
  always @(posedge clock_i) begin
    refcnt   <= refcnt + 2'h1;
    if (refcnt == 2'h3) ref_clk <= ~ref_clk;
    cyc      <= cyc + 1;
    sda_prev <= bus_if.sda_line;
    en_prev  <= en_o;
    if (bus_if.scl_line && bus_if.sda_line && !sda_prev) stop_cyc <= cyc;
    if (en_o !== en_prev) chg_cyc <= cyc;
  end

  // expected divider period in clock_i cycles; the reference runs at eight cycles
  function automatic logic [31:0] exp_period(input int sel);
    return 32'h0000_0008 << sel;
  endfunction

  // an enable output is the inverse of its mask bit
  function automatic logic [31:0] exp_enable(input logic [7:0] m);
    return {24'h00_0000, ~m};
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic hang;
    errors++;
    tally_and_finish();
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    rd  = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one whole transfer; rd ends holding the final status word
  task automatic xfer(input logic [6:0] a, input logic rw, input logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, `CDF_REG_CTRL, {8'h00, d, 7'h00, rw, 1'b0, a});
    do begin
      apb(1'b0, `CDF_REG_STAT, 32'h0000_0000);
      n++;
    end while (rd[`CDF_STAT_BUSY_BIT] !== 1'b0 && n < 2000);
    if (n >= 2000) hang();
  endtask

  // clock_i cycles between two rising edges of pair 0
  task automatic period;
    int n;
    int r;
    logic pv;
    n  = 0;
    r  = 0;
    p  = 32'h0000_0000;
    pv = 1'b1;
    while (r < 2 && n < 500) begin
      @(posedge clock_i);
      n++;
      if (r == 1) p++;
      if (pair[0] === 1'b1 && pv === 1'b0) r++;
      pv = pair[0];
    end
    if (n >= 500) hang();
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fs_hi, fs_lo, ad_hi, ad_lo, ref_clk, refcnt, sda_prev, en_prev} = '0;
    {errors, checks_done, cyc, stop_cyc, chg_cyc} = '0;
    clk_en = 1'b1;
    seed  = 41;
    rst_i = 1'b1;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    cmp({24'h00_0000, en_o}, 32'h0000_00FF);
    for (int c = 0; c < 4; c++) begin
      fs_hi <= c[1];
      fs_lo <= c[0];
      repeat (100) @(posedge clock_i);
      period();
      cmp(p, exp_period(c));
      cmp({16'h0000, pair, pair_n}, {16'h0000, {8{pair[0]}}, {8{~pair[0]}}});
    end
    for (int i = 0; i < 6; i++) begin
      ad_hi <= i[1];
      ad_lo <= i[0];
      mask = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($random(seed));
      old  = en_o;
      xfer({`CDF_ADDR_FIXED, i[1], i[0]}, 1'b0, mask);
      cmp({29'h0000_0000, rd[2:0]}, 32'h0000_0004);
      cmp({24'h00_0000, en_o}, exp_enable(mask));
      if (old !== ~mask) cmp({31'h0000_0000, (chg_cyc - stop_cyc) inside {[0:40]}}, 32'h0000_0001);
      xfer({`CDF_ADDR_FIXED, i[1], i[0]}, 1'b1, 8'h00);
      cmp({24'h00_0000, rd[15:8]}, {24'h00_0000, mask});
    end
    // wrong strap bit, then wrong fixed part: no acknowledge, mask kept
    xfer({`CDF_ADDR_FIXED, ~ad_hi, ad_lo}, 1'b0, ~mask);
    cmp({30'h0000_0000, rd[1:0]}, 32'h0000_0002);
    xfer({5'h1B, ad_hi, ad_lo}, 1'b0, ~mask);
    cmp({24'h00_0000, en_o}, exp_enable(mask));
    // a start while busy is refused: the queued matching write must not land
    apb(1'b1, `CDF_REG_CTRL, {8'h00, ~mask, 7'h00, 1'b0, 1'b0, 5'h1B, ad_hi, ad_lo});
    xfer({`CDF_ADDR_FIXED, ad_hi, ad_lo}, 1'b0, 8'h00);
    cmp({24'h00_0000, en_o}, exp_enable(mask));
    apb(1'b0, `CDF_REG_CTRL, 32'h0000_0000);
    cmp({slv, rd[30:0]}, {1'b0, 7'h00, ~mask, 7'h00, 1'b0, 1'b0, 5'h1B, ad_hi, ad_lo});
    // unmapped offset answers with an error and zero data
    apb(1'b0, 12'h008, 32'h0000_0000);
    cmp({slv, rd[30:0]}, 32'h8000_0000);
    // clock enable low freezes the divider; at divide by 8 a half period is 32 cycles
    clk_en <= 1'b0;
    @(posedge clock_i);
    old = pair;
    repeat (40) @(posedge clock_i);
    cmp({24'h00_0000, pair}, {24'h00_0000, old});
    clk_en <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    cmp({24'h00_0000, en_o}, 32'h0000_00FF);
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    tally_and_finish();
  end
endmodule
`default_nettype wire
